// *** intc_pkg.sv ***
// constants shared by the two-level interrupt controller
package intc_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_SYSCTL  = 16'hfff2;
    localparam logic [15:0] IDX_SENSE   = 16'hfff4;
    localparam logic [15:0] IDX_ENABLE  = 16'hfff5;
    localparam logic [15:0] IDX_FLAG    = 16'hfff6;
    localparam logic [15:0] IDX_PRIO_A  = 16'hfff8;
    localparam logic [15:0] IDX_PRIO_B  = 16'hfff9;

    // reset values
    localparam logic [7:0] RST_SYSCTL  = 8'h0b;
    localparam logic [7:0] RST_SENSE   = 8'h00;
    localparam logic [7:0] RST_ENABLE  = 8'h00;
    localparam logic [7:0] RST_FLAG    = 8'h00;
    localparam logic [7:0] RST_PRIO_A  = 8'h00;
    localparam logic [7:0] RST_PRIO_B  = 8'h00;

    // system control fields
    localparam int SYS_USER_BIT_SELECT   = 3;
    localparam int SYS_NONMASK_EDGE_SEL  = 2;

    // request flag, enable and sense bit of each external pin
    localparam int EXT_PINS = 4;
    localparam logic [7:0] FLAG_MASK = 8'h33;
    localparam int EXT_BIT_ZERO = 0;
    localparam int EXT_BIT_ONE  = 1;
    localparam int EXT_BIT_FOUR = 4;
    localparam int EXT_BIT_FIVE = 5;

    // priority bits per source
    localparam int PA_REQ_ZERO = 7;
    localparam int PA_REQ_ONE  = 6;
    localparam int PA_REQ_45   = 4;
    localparam int PA_WDOG     = 3;
    localparam int PA_TMR0     = 2;
    localparam int PA_TMR1     = 1;
    localparam int PA_TMR2     = 0;
    localparam int PB_TMR3     = 7;
    localparam int PB_TMR4     = 6;
    localparam int PB_SER0     = 3;
    localparam int PB_SER1     = 2;
    localparam int PB_ADC      = 1;

    // maskable sources: 4 external then 9 internal modules
    localparam int SRC_COUNT = 13;
    localparam int INT_COUNT = 9;

    // vector numbers
    localparam logic [7:0] VEC_NONMASK  = 8'h07;
    localparam logic [7:0] VEC_REQ_ZERO = 8'h0c;
    localparam logic [7:0] VEC_REQ_ONE  = 8'h0d;
    localparam logic [7:0] VEC_REQ_FOUR = 8'h10;
    localparam logic [7:0] VEC_REQ_FIVE = 8'h11;
    localparam logic [7:0] VEC_INT_BASE = 8'h14;

endpackage

// *** intc_edge_detect.sv ***
// edge detector with selectable polarity, primed after reset
`timescale 1ns/1ps
module intc_edge_detect (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and selection
    input  wire logic pin,
    input  wire logic rise_sel,
    // one-cycle edge pulse
    output logic      edge_pulse
);

    logic prev_q;
    logic primed_q;

    // remember the last level; no edge in the first cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q   <= 1'b1;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= pin;
            primed_q <= 1'b1;
        end
    end

    // rising when selected, else falling
    assign edge_pulse = primed_q & (rise_sel ? (pin & ~prev_q) : (~pin & prev_q));

endmodule

// *** intc_pick.sv ***
// fixed-order picker: lowest index among requests wins
`timescale 1ns/1ps
module intc_pick (
    // request vector
    input  wire logic [intc_pkg::SRC_COUNT-1:0] req,
    // result
    output logic                                found,
    output logic [3:0]                          idx
);

    // scan down so the lowest set index is the last one kept
    always_comb begin
        found = 1'b0;
        idx   = 4'h0;
        for (int i = intc_pkg::SRC_COUNT - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = 4'(i);
            end
        end
    end

endmodule

// *** intc_top.sv ***
// two-level interrupt controller with apb register access
//
// Overview of operation
// - nonmaskable request always wins, never masked
// - each maskable source gets one of two levels
// - three-level masking from mask and user bits
// - every source presents its own vector
// - each external pin: falling edge or level
// - control register reset by reset or standby
// - user select 0 makes user bit a mask
// - edge select 0 falling, 1 rising
// - priority register a clears on reset, standby
// - top bit: external request zero level
// - next bit: external request one level
// - reserved priority bit stored, no effect
// - flags accept only zero writes, clearing
// - lower bits: four/five, watchdog, timers
// - flag clears on zero after read one
`timescale 1ns/1ps
module intc_top (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic        HW_STANDBY,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [17:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // request pins, active low for the external four
    input  wire logic        NONMASK_PIN,
    input  wire logic        EXT_REQUEST_ZERO_N,
    input  wire logic        EXT_REQUEST_ONE_N,
    input  wire logic        EXT_REQUEST_FOUR_N,
    input  wire logic        EXT_REQUEST_FIVE_N,
    // internal module requests, levels
    input  wire logic [8:0]  MODULE_REQ,
    // cpu condition code bits
    input  wire logic        COND_CODE_MASK,
    input  wire logic        USER_MASK_BIT,
    // cpu exception interface
    input  wire logic        IRQ_ACK,
    output logic             IRQ_REQ,
    output logic             IRQ_NONMASK,
    output logic      [7:0]  IRQ_VECTOR
);

    typedef enum logic [1:0] {
        AP_IDLE = 2'b00,
        AP_DONE = 2'b01
    } apb_state_e;

    apb_state_e apb_state_q;
    apb_state_e apb_state_d;

    logic [7:0]  system_ctrl_reg_q;
    logic [7:0]  sense_select_reg_q;
    logic [7:0]  request_enable_reg_q;
    logic [7:0]  request_flag_reg_q;
    logic [7:0]  request_flag_reg_d;
    logic [7:0]  priority_reg_a_q;
    logic [7:0]  priority_reg_b_q;
    logic [7:0]  read_seen_q;
    logic [7:0]  read_seen_d;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        nonmask_pend_q;
    logic        irq_req_q;
    logic        irq_nonmask_q;
    logic [7:0]  irq_vector_q;

    logic        init;
    logic [15:0] reg_idx;
    logic        mapped;
    logic [7:0]  rd_value;
    logic        wr_done;
    logic        rd_done;
    logic [7:0]  wbyte;
    logic [3:0]  ext_pin_n;
    logic [3:0]  ext_edge;
    logic [7:0]  ext_low;
    logic [7:0]  ext_fall;
    logic        nonmask_edge;
    logic        user_bit_select;
    logic        accept_all;
    logic        accept_high;
    logic [intc_pkg::SRC_COUNT-1:0] src_req;
    logic [intc_pkg::SRC_COUNT-1:0] src_prio;
    logic [intc_pkg::SRC_COUNT-1:0] src_pass;
    logic        hi_found;
    logic        lo_found;
    logic [3:0]  hi_idx;
    logic [3:0]  lo_idx;
    logic [3:0]  win_idx;
    logic        ack_nonmask;
    logic [7:0]  ack_clear;

    // flag bit position of each external pin
    function automatic int ext_bit(input int n);
        case (n)
            0:       ext_bit = intc_pkg::EXT_BIT_ZERO;
            1:       ext_bit = intc_pkg::EXT_BIT_ONE;
            2:       ext_bit = intc_pkg::EXT_BIT_FOUR;
            default: ext_bit = intc_pkg::EXT_BIT_FIVE;
        endcase
    endfunction

    // vector of each maskable source
    function automatic logic [7:0] vec_of(input logic [3:0] idx);
        case (idx)
            4'h0:    vec_of = intc_pkg::VEC_REQ_ZERO;
            4'h1:    vec_of = intc_pkg::VEC_REQ_ONE;
            4'h2:    vec_of = intc_pkg::VEC_REQ_FOUR;
            4'h3:    vec_of = intc_pkg::VEC_REQ_FIVE;
            default: vec_of = intc_pkg::VEC_INT_BASE + 8'(idx) - 8'h04;
        endcase
    endfunction

    // hardware standby acts like reset on the registers
    assign init = RESET | HW_STANDBY;

    assign reg_idx = PADDR[17:2];
    assign wbyte   = PWDATA[7:0];

    // address decode and read mux
    always_comb begin
        mapped   = 1'b1;
        rd_value = 8'h00;
        if (reg_idx == intc_pkg::IDX_SYSCTL) begin
            rd_value = system_ctrl_reg_q;
        end else if (reg_idx == intc_pkg::IDX_SENSE) begin
            rd_value = sense_select_reg_q;
        end else if (reg_idx == intc_pkg::IDX_ENABLE) begin
            rd_value = request_enable_reg_q;
        end else if (reg_idx == intc_pkg::IDX_FLAG) begin
            rd_value = request_flag_reg_q & intc_pkg::FLAG_MASK;
        end else if (reg_idx == intc_pkg::IDX_PRIO_A) begin
            rd_value = priority_reg_a_q;
        end else if (reg_idx == intc_pkg::IDX_PRIO_B) begin
            rd_value = priority_reg_b_q;
        end else begin
            mapped = 1'b0;
        end
    end

    // two-state access sequencer: one wait cycle then ready
    always_comb begin
        case (apb_state_q)
            AP_IDLE: apb_state_d = (PSEL & PENABLE) ? AP_DONE : AP_IDLE;
            default: apb_state_d = AP_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            apb_state_q <= AP_IDLE;
        end else begin
            apb_state_q <= apb_state_d;
        end
    end

    // read data and error captured in the wait cycle
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (apb_state_q == AP_IDLE && PSEL && PENABLE) begin
            prdata_q  <= {24'h00_0000, rd_value};
            pslverr_q <= ~mapped;
        end
    end

    assign PREADY  = (apb_state_q == AP_DONE);
    assign PRDATA  = prdata_q;
    assign PSLVERR = PREADY & pslverr_q;
    assign wr_done = PREADY & PSEL & PENABLE & PWRITE & mapped;
    assign rd_done = PREADY & PSEL & PENABLE & ~PWRITE;

    always_ff @(posedge REF_CLK) begin
        if (init) begin
            system_ctrl_reg_q <= intc_pkg::RST_SYSCTL;
        end else if (wr_done && reg_idx == intc_pkg::IDX_SYSCTL) begin
            system_ctrl_reg_q <= wbyte;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (init) begin
            sense_select_reg_q   <= intc_pkg::RST_SENSE;
            request_enable_reg_q <= intc_pkg::RST_ENABLE;
        end else if (wr_done && reg_idx == intc_pkg::IDX_SENSE) begin
            sense_select_reg_q   <= wbyte;
        end else if (wr_done && reg_idx == intc_pkg::IDX_ENABLE) begin
            request_enable_reg_q <= wbyte;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (init) begin
            priority_reg_a_q <= intc_pkg::RST_PRIO_A;
            priority_reg_b_q <= intc_pkg::RST_PRIO_B;
        end else if (wr_done && reg_idx == intc_pkg::IDX_PRIO_A) begin
            priority_reg_a_q <= wbyte;
        end else if (wr_done && reg_idx == intc_pkg::IDX_PRIO_B) begin
            priority_reg_b_q <= wbyte;
        end
    end

    assign user_bit_select = system_ctrl_reg_q[intc_pkg::SYS_USER_BIT_SELECT];

    assign ext_pin_n = {EXT_REQUEST_FIVE_N, EXT_REQUEST_FOUR_N,
                        EXT_REQUEST_ONE_N, EXT_REQUEST_ZERO_N};

    // nonmaskable edge, polarity from system control
    intc_edge_detect u_nonmask_edge (
        .clk        (REF_CLK),
        .rst        (init),
        .pin        (NONMASK_PIN),
        .rise_sel   (system_ctrl_reg_q[intc_pkg::SYS_NONMASK_EDGE_SEL]),
        .edge_pulse (nonmask_edge)
    );

    // one falling-edge detector per external pin
    generate
        for (genvar g = 0; g < intc_pkg::EXT_PINS; g++) begin : g_ext
            intc_edge_detect u_ext_edge (
                .clk        (REF_CLK),
                .rst        (init),
                .pin        (ext_pin_n[g]),
                .rise_sel   (1'b0),
                .edge_pulse (ext_edge[g])
            );
        end
    endgenerate

    // spread pin events onto flag bit positions
    always_comb begin
        ext_low  = 8'h00;
        ext_fall = 8'h00;
        for (int n = 0; n < intc_pkg::EXT_PINS; n++) begin
            ext_low[ext_bit(n)]  = ~ext_pin_n[n];
            ext_fall[ext_bit(n)] = ext_edge[n];
        end
    end

    // nonmaskable pending, cleared when its exception is taken
    always_ff @(posedge REF_CLK) begin
        if (init) begin
            nonmask_pend_q <= 1'b0;
        end else if (nonmask_edge) begin
            nonmask_pend_q <= 1'b1;
        end else if (ack_nonmask) begin
            nonmask_pend_q <= 1'b0;
        end
    end

    // ack clear: edge mode, or level mode with pin high
    always_comb begin
        ack_clear = 8'h00;
        for (int n = 0; n < intc_pkg::EXT_PINS; n++) begin
            if (IRQ_ACK && irq_req_q && !irq_nonmask_q &&
                irq_vector_q == vec_of(4'(n))) begin
                ack_clear[ext_bit(n)] = sense_select_reg_q[ext_bit(n)] |
                                        ext_pin_n[n];
            end
        end
    end

    // flag update: set beats any clear in the same cycle
    always_comb begin
        request_flag_reg_d = request_flag_reg_q & ~ack_clear;
        read_seen_d        = read_seen_q;
        if (rd_done && reg_idx == intc_pkg::IDX_FLAG) begin
            read_seen_d = read_seen_q | request_flag_reg_q;
        end
        if (wr_done && reg_idx == intc_pkg::IDX_FLAG) begin
            // only a zero written over a seen one clears; ones are ignored
            request_flag_reg_d = request_flag_reg_d & ~(read_seen_q & ~wbyte);
            read_seen_d        = read_seen_d & wbyte;
        end
        // sense bit 1: falling edge, 0: low level
        request_flag_reg_d = (request_flag_reg_d |
                              (sense_select_reg_q & ext_fall) |
                              (~sense_select_reg_q & ext_low)) & intc_pkg::FLAG_MASK;
    end

    always_ff @(posedge REF_CLK) begin
        if (init) begin
            request_flag_reg_q <= intc_pkg::RST_FLAG;
            read_seen_q        <= 8'h00;
        end else begin
            request_flag_reg_q <= request_flag_reg_d;
            read_seen_q        <= read_seen_d & request_flag_reg_d;
        end
    end

    // source list: four pins first, then the internal modules
    always_comb begin
        src_req = {MODULE_REQ, 4'h0};
        for (int n = 0; n < intc_pkg::EXT_PINS; n++) begin
            src_req[n] = request_flag_reg_q[ext_bit(n)] & request_enable_reg_q[ext_bit(n)];
        end
    end

    // level of each source from its priority bit
    always_comb begin
        src_prio[0]  = priority_reg_a_q[intc_pkg::PA_REQ_ZERO];
        src_prio[1]  = priority_reg_a_q[intc_pkg::PA_REQ_ONE];
        src_prio[2]  = priority_reg_a_q[intc_pkg::PA_REQ_45];
        src_prio[3]  = priority_reg_a_q[intc_pkg::PA_REQ_45];
        src_prio[4]  = priority_reg_a_q[intc_pkg::PA_WDOG];
        src_prio[5]  = priority_reg_a_q[intc_pkg::PA_TMR0];
        src_prio[6]  = priority_reg_a_q[intc_pkg::PA_TMR1];
        src_prio[7]  = priority_reg_a_q[intc_pkg::PA_TMR2];
        src_prio[8]  = priority_reg_b_q[intc_pkg::PB_TMR3];
        src_prio[9]  = priority_reg_b_q[intc_pkg::PB_TMR4];
        src_prio[10] = priority_reg_b_q[intc_pkg::PB_SER0];
        src_prio[11] = priority_reg_b_q[intc_pkg::PB_SER1];
        src_prio[12] = priority_reg_b_q[intc_pkg::PB_ADC];
    end

    // mask clear: all; user bit as mask and clear: high only
    assign accept_all  = ~COND_CODE_MASK;
    assign accept_high = COND_CODE_MASK & ~user_bit_select & ~USER_MASK_BIT;
    assign src_pass    = src_req & ({intc_pkg::SRC_COUNT{accept_all}} |
                                    ({intc_pkg::SRC_COUNT{accept_high}} & src_prio));

    intc_pick u_pick_high (
        .req   (src_pass & src_prio),
        .found (hi_found),
        .idx   (hi_idx)
    );

    intc_pick u_pick_low (
        .req   (src_pass & ~src_prio),
        .found (lo_found),
        .idx   (lo_idx)
    );

    assign win_idx     = hi_found ? hi_idx : lo_idx;
    assign ack_nonmask = IRQ_ACK & irq_req_q & irq_nonmask_q;

    // registered request and vector to the cpu
    always_ff @(posedge REF_CLK) begin
        if (init) begin
            irq_req_q     <= 1'b0;
            irq_nonmask_q <= 1'b0;
            irq_vector_q  <= 8'h00;
        end else if (nonmask_pend_q && !ack_nonmask) begin
            irq_req_q     <= 1'b1;
            irq_nonmask_q <= 1'b1;
            irq_vector_q  <= intc_pkg::VEC_NONMASK;
        end else begin
            irq_req_q     <= hi_found | lo_found;
            irq_nonmask_q <= 1'b0;
            irq_vector_q  <= vec_of(win_idx);
        end
    end

    assign IRQ_REQ     = irq_req_q;
    assign IRQ_NONMASK = irq_nonmask_q;
    assign IRQ_VECTOR  = irq_vector_q;

endmodule

// *** intc_chk.sv ***
// port checker for the two-level interrupt controller
`timescale 1ns/1ps
module intc_chk (
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        HW_STANDBY,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [17:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // pins and cpu side
    input wire logic        NONMASK_PIN,
    input wire logic        COND_CODE_MASK,
    input wire logic        USER_MASK_BIT,
    input wire logic        IRQ_REQ,
    input wire logic        IRQ_NONMASK,
    input wire logic [7:0]  IRQ_VECTOR
);
    logic [7:0]  sys_q;
    logic [1:0]  live_q;
    logic [15:0] idx;
    logic        mapped;
    logic        mask_all;
    // decode and full mask
    assign idx = PADDR[17:2];
    assign mapped = idx inside {intc_pkg::IDX_SYSCTL, intc_pkg::IDX_SENSE, intc_pkg::IDX_ENABLE,
        intc_pkg::IDX_FLAG, intc_pkg::IDX_PRIO_A, intc_pkg::IDX_PRIO_B};
    assign mask_all = COND_CODE_MASK && (sys_q[intc_pkg::SYS_USER_BIT_SELECT] || USER_MASK_BIT);
    // control register shadow
    always_ff @(posedge REF_CLK) begin
        if (RESET || HW_STANDBY) begin
            sys_q <= intc_pkg::RST_SYSCTL;
        end else if (PSEL && PENABLE && PREADY && PWRITE && idx == intc_pkg::IDX_SYSCTL) begin
            sys_q <= PWDATA[7:0];
        end
    end
    // edge logic is blind just after reset
    always_ff @(posedge REF_CLK) begin
        if (RESET || HW_STANDBY) begin
            live_q <= 2'h0;
        end else if (live_q != 2'h3) begin
            live_q <= live_q + 2'h1;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence wait_s;
        PSEL && PENABLE && !PREADY ##1 PREADY;
    endsequence
    sequence nmi_edge_s;
        live_q == 2'h3 && (sys_q[intc_pkg::SYS_NONMASK_EDGE_SEL] ?
            $rose(NONMASK_PIN) : $fell(NONMASK_PIN));
    endsequence
    a_ready_wait: assert property (setup_s |=> wait_s)
        else $error("late pready");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("long pready");
    a_err_decode: assert property (PREADY |-> PSLVERR == !mapped)
        else $error("bad pslverr");
    a_reset_quiet: assert property ($fell(RESET) |-> !IRQ_REQ && !PREADY && PRDATA == 32'h0)
        else $error("busy after reset");
    a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    a_flag_reserved: assert property (PREADY && !PWRITE && idx == intc_pkg::IDX_FLAG |->
        (PRDATA[7:0] & ~intc_pkg::FLAG_MASK) == 8'h00) else $error("reserved flag set");
    a_nmi_vector: assert property (IRQ_NONMASK |->
        IRQ_REQ && IRQ_VECTOR == intc_pkg::VEC_NONMASK) else $error("bad nmi vector");
    a_mask_levels: assert property (IRQ_REQ && !IRQ_NONMASK |-> !$past(mask_all))
        else $error("request while masked");
    a_nmi_taken: assert property (nmi_edge_s |-> ##[1:4] IRQ_NONMASK)
        else $error("nmi edge lost");
endmodule

bind intc_top intc_chk chk (.REF_CLK(REF_CLK), .RESET(RESET), .HW_STANDBY(HW_STANDBY),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .NONMASK_PIN(NONMASK_PIN),
    .COND_CODE_MASK(COND_CODE_MASK), .USER_MASK_BIT(USER_MASK_BIT), .IRQ_REQ(IRQ_REQ),
    .IRQ_NONMASK(IRQ_NONMASK), .IRQ_VECTOR(IRQ_VECTOR));

// *** cpu_model.sv ***
// cpu and module model: acks requests, drops served module lines
`timescale 1ns/1ps
module cpu_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // bench control
    input  wire logic       ack_en,
    input  wire logic [8:0] mod_set,
    // controller outputs
    input  wire logic       irq_req,
    input  wire logic [7:0] irq_vector,
    // acknowledge and module requests
    output logic            irq_ack,
    output logic [8:0]      module_req
);
    logic [1:0] gap_q;
    logic [7:0] slot;
    logic [8:0] served;
    // module slot of the vector being taken
    assign slot = irq_vector - intc_pkg::VEC_INT_BASE;
    assign served = (irq_ack && irq_req && slot < 8'h09) ? (9'h001 << slot) : 9'h000;
    // one ack pulse per exception, then a quiet gap
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ack <= 1'b0;
            gap_q <= 2'h0;
        end else if (irq_ack || gap_q != 2'h0) begin
            irq_ack <= 1'b0;
            gap_q <= gap_q + 2'h1;
        end else begin
            irq_ack <= ack_en && irq_req;
        end
    end
    // a module holds its request until served
    always_ff @(posedge clk) begin
        if (rst) begin
            module_req <= 9'h000;
        end else begin
            module_req <= (module_req | mod_set) & ~served;
        end
    end
endmodule

// *** two_level_interrupt_controller_tb.sv ***
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module two_level_interrupt_controller_tb;
    logic        ref_clk, reset, hw_standby, psel, penable, pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, nonmask_pin, cc_mask, user_mask, ack_en;
    logic        irq_ack, irq_req, irq_nonmask;
    logic [3:0]  ext_n;
    logic [7:0]  irq_vector, rnd;
    logic [8:0]  mod_set, module_req;
    logic [32:0] rd_q[$];
    logic [8:0]  vec_q[$];
    int          miscompares, total_checks, seed;

    intc_top uut (.REF_CLK(ref_clk), .RESET(reset), .HW_STANDBY(hw_standby), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .NONMASK_PIN(nonmask_pin),
        .EXT_REQUEST_ZERO_N(ext_n[0]), .EXT_REQUEST_ONE_N(ext_n[1]),
        .EXT_REQUEST_FOUR_N(ext_n[2]), .EXT_REQUEST_FIVE_N(ext_n[3]), .MODULE_REQ(module_req),
        .COND_CODE_MASK(cc_mask), .USER_MASK_BIT(user_mask), .IRQ_ACK(irq_ack),
        .IRQ_REQ(irq_req), .IRQ_NONMASK(irq_nonmask), .IRQ_VECTOR(irq_vector));
    cpu_model cpu (.clk(ref_clk), .rst(reset), .ack_en(ack_en), .mod_set(mod_set),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .module_req(module_req));

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check_rd(input logic [32:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED apb read exp %h got %h", exp, got);
        end
    endtask

    task automatic check_vec(input logic [8:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED vector exp %h got %h", exp, got);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                       input logic [32:0] exp);
        if (!wr) rd_q.push_back(exp);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'($random(seed)), d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, {25'h0, exp});
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 33'h0);
    endtask

    // drain noted vectors, none left
    task automatic wait_vec;
        repeat (100) if (vec_q.size() != 0) @(posedge ref_clk);
        repeat (10) @(posedge ref_clk);
        check_vec(9'h000, 9'(vec_q.size()));
        vec_q.delete();
    endtask

    // compare each result with the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) begin
            check_rd(rd_q.size() ? rd_q.pop_front() : 33'h0, {pslverr, prdata});
        end
        if (irq_ack && irq_req) begin
            check_vec(vec_q.size() ? vec_q.pop_front() : 9'h0, {irq_nonmask, irq_vector});
        end
    end

    // watchdog
    initial begin
        #200000;
        miscompares++;
        results;
    end

    // main sequence
    initial begin
        seed = 96724;
        miscompares = 0;
        total_checks = 0;
        {reset, hw_standby, psel, penable, pwrite, paddr, pwdata} = {1'b1, 54'h0};
        {nonmask_pin, cc_mask, user_mask, ack_en, ext_n, mod_set} = {1'b1, 3'h0, 4'hf, 9'h0};
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        // reset values, unmapped index
        rd(intc_pkg::IDX_SYSCTL, 8'h0b);
        rd(intc_pkg::IDX_SENSE, 8'h00);
        rd(intc_pkg::IDX_ENABLE, 8'h00);
        rd(intc_pkg::IDX_FLAG, 8'h00);
        rd(intc_pkg::IDX_PRIO_A, 8'h00);
        rd(intc_pkg::IDX_PRIO_B, 8'h00);
        apb(1'b0, 16'hfff3, 8'h00, 33'h100000000);
        // random priority kept, standby restores
        rnd = 8'($random(seed));
        wr(intc_pkg::IDX_PRIO_A, rnd);
        rd(intc_pkg::IDX_PRIO_A, rnd);
        wr(intc_pkg::IDX_SYSCTL, 8'h07);
        hw_standby <= 1'b1;
        repeat (2) @(posedge ref_clk);
        hw_standby <= 1'b0;
        rd(intc_pkg::IDX_SYSCTL, 8'h0b);
        rd(intc_pkg::IDX_PRIO_A, 8'h00);
        // level mode flag stays after the pin rises
        ext_n[1] <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ext_n[1] <= 1'b1;
        rd(intc_pkg::IDX_FLAG, 8'h02);
        wr(intc_pkg::IDX_FLAG, 8'h00);
        // edge flag: ones ignored, zero clears after read
        wr(intc_pkg::IDX_SENSE, intc_pkg::FLAG_MASK);
        wr(intc_pkg::IDX_ENABLE, intc_pkg::FLAG_MASK);
        ext_n[0] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(intc_pkg::IDX_FLAG, 8'h01);
        wr(intc_pkg::IDX_FLAG, 8'hff);
        rd(intc_pkg::IDX_FLAG, 8'h01);
        wr(intc_pkg::IDX_FLAG, 8'h00);
        rd(intc_pkg::IDX_FLAG, 8'h00);
        ext_n[0] <= 1'b1;
        // four pins at once, one high, reserved bit set
        wr(intc_pkg::IDX_PRIO_A, 8'h60);
        vec_q.push_back({1'b0, intc_pkg::VEC_REQ_ONE});
        vec_q.push_back({1'b0, intc_pkg::VEC_REQ_ZERO});
        vec_q.push_back({1'b0, intc_pkg::VEC_REQ_FOUR});
        vec_q.push_back({1'b0, intc_pkg::VEC_REQ_FIVE});
        ext_n <= 4'h0;
        ack_en <= 1'b1;
        wait_vec;
        ext_n <= 4'hf;
        // masking: all, via user bit, high only, none
        wr(intc_pkg::IDX_PRIO_B, 8'h02);
        cc_mask <= 1'b1;
        user_mask <= 1'b1;
        mod_set <= 9'h101;
        @(posedge ref_clk);
        mod_set <= 9'h000;
        repeat (10) @(posedge ref_clk);
        wr(intc_pkg::IDX_SYSCTL, 8'h03);
        repeat (10) @(posedge ref_clk);
        vec_q.push_back({1'b0, intc_pkg::VEC_INT_BASE + 8'h08});
        user_mask <= 1'b0;
        wait_vec;
        vec_q.push_back({1'b0, intc_pkg::VEC_INT_BASE});
        cc_mask <= 1'b0;
        wait_vec;
        // nonmaskable while masked: falling, then rising
        cc_mask <= 1'b1;
        user_mask <= 1'b1;
        vec_q.push_back({1'b1, intc_pkg::VEC_NONMASK});
        nonmask_pin <= 1'b0;
        wait_vec;
        wr(intc_pkg::IDX_SYSCTL, 8'h07);
        vec_q.push_back({1'b1, intc_pkg::VEC_NONMASK});
        nonmask_pin <= 1'b1;
        wait_vec;
        results;
    end
endmodule
